//--- verilog/pcl_load_sequencer.v
// configuration load sequencer: request, status, byte capture, initialization
`timescale 1ns/1ps
`default_nettype none
`include "pcl_defs.vh"

// Overview of operation
// - in user mode all three lines high; request low restarts loading
// - status held low for whole power-on delay before accepting activity
// - done low from power-up through loading, high only when complete
// - request fall drives done and status low within 500 ns
// - own status low pulse lasts 45 to 230 us; held past 230 us while request stays low
// - status released within 230 us of request rising
// - with internal oscillator, user mode within 650 us of done
// - data pins become user pins after loading, per dual-purpose option
// - one byte sampled per rising load clock edge until done
// - user clock initialization: enable after interval, then 3192 cycles
module pcl_load_sequencer
#(
  parameter STAT_CYC   = `PCL_STAT_MIN_CYC,
  parameter INIT_CYC   = `PCL_CD2UM_CYC / 2,
  parameter POR_CYC    = `PCL_STAT_MIN_CYC,
  parameter BYTE_COUNT = 16
)
(
  // clock and reset
  input  wire                   sys_clk_i,
  input  wire                   sys_rst_i,
  // configuration pins
  input  wire                   config_request_n_i,
  input  wire                   load_status_n_i,
  output wire                   load_status_n_o,
  output wire                   load_status_n_oe_n_o,
  input  wire                   load_done_i,
  output wire                   load_done_o,
  output wire                   load_done_oe_n_o,
  input  wire                   parallel_load_clock_i,
  input  wire [`PCL_DATA_W-1:0] load_data_i,
  input  wire                   user_init_clock_i,
  input  wire                   user_init_clock_sel_i,
  // dual-purpose pin option and user-mode data pin control
  input  wire                   data_pins_user_en_i,
  output reg                    data_pins_user_o,
  // captured byte stream
  output wire                   byte_valid_o,
  output wire [`PCL_DATA_W-1:0] byte_data_o,
  input  wire                   byte_ready_i,
  // state
  output reg                    init_done_o,
  output reg                    user_mode_o,
  output wire                   load_stall_o
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [5:0] ST_POR  = 6'h01;
  localparam [5:0] ST_RST  = 6'h02;
  localparam [5:0] ST_WAIT = 6'h04;
  localparam [5:0] ST_LOAD = 6'h08;
  localparam [5:0] ST_INIT = 6'h10;
  localparam [5:0] ST_USER = 6'h20;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg [1:0] req_s_reg;
  reg [1:0] stat_s_reg;
  reg [1:0] parallel_load_clock_s_reg;
  reg [1:0] uclk_s_reg;
  reg [1:0] done_s_reg;
  reg [`PCL_DATA_W-1:0] data_s1_reg;
  reg [`PCL_DATA_W-1:0] data_s2_reg;
  reg parallel_load_clock_d_reg;
  reg uclk_d_reg;

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      req_s_reg   <= 2'h3;
      stat_s_reg  <= 2'h3;
      parallel_load_clock_s_reg  <= 2'h0;
      uclk_s_reg  <= 2'h0;
      done_s_reg  <= 2'h0;
      data_s1_reg <= `PCL_BYTE_ZERO;
      data_s2_reg <= `PCL_BYTE_ZERO;
      parallel_load_clock_d_reg  <= 1'b0;
      uclk_d_reg  <= 1'b0;
    end
    else
    begin
      req_s_reg   <= {req_s_reg[0], config_request_n_i};
      stat_s_reg  <= {stat_s_reg[0], load_status_n_i};
      parallel_load_clock_s_reg  <= {parallel_load_clock_s_reg[0], parallel_load_clock_i};
      uclk_s_reg  <= {uclk_s_reg[0], user_init_clock_i};
      done_s_reg  <= {done_s_reg[0], load_done_i};
      data_s1_reg <= load_data_i;
      data_s2_reg <= data_s1_reg;
      parallel_load_clock_d_reg  <= parallel_load_clock_s_reg[1];
      uclk_d_reg  <= uclk_s_reg[1];
    end
  end

  wire req_low   = ~req_s_reg[1];
  wire stat_high = stat_s_reg[1];
  wire parallel_load_clock_rise = parallel_load_clock_s_reg[1] & ~parallel_load_clock_d_reg;
  wire parallel_load_clock_fall = ~parallel_load_clock_s_reg[1] & parallel_load_clock_d_reg;
  wire uclk_rise = uclk_s_reg[1] & ~uclk_d_reg;
  // another device holding done low delays initialization
  wire done_high = done_s_reg[1];

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  reg [5:0]            state_reg;
  reg [5:0]            state_next;
  reg [`PCL_CNT_W-1:0] cnt_reg;
  reg [`PCL_CNT_W-1:0] cnt_next;
  reg [`PCL_CNT_W-1:0] bytes_reg;
  reg [1:0]            edges_reg;
  reg                  stat_drv_reg;
  reg                  done_reg;
  wire                 buf_ready;
  reg [`PCL_CNT_W-1:0] cu_cnt_reg;
  wire                 uclk_en = (cu_cnt_reg >= `PCL_CD2CU_CYC);
  wire                 take = (state_reg == ST_LOAD) && parallel_load_clock_rise && !done_reg;

  always @*
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg + `PCL_CNT_ONE;
    case (state_reg)
      ST_POR:
        if (cnt_reg >= POR_CYC[`PCL_CNT_W-1:0])
        begin
          state_next = ST_WAIT;
          cnt_next   = `PCL_CNT_ZERO;
        end
      ST_RST:
        // status pulse at least the minimum, held while request stays low
        if (cnt_reg >= STAT_CYC[`PCL_CNT_W-1:0] && !req_low)
        begin
          state_next = ST_WAIT;
          cnt_next   = `PCL_CNT_ZERO;
        end
      ST_WAIT:
        if (stat_high)
          state_next = ST_LOAD;
      ST_LOAD:
        if (done_reg && done_high && edges_reg == `PCL_DONE_EDGES)
        begin
          state_next = ST_INIT;
          cnt_next   = `PCL_CNT_ZERO;
        end
        else
          cnt_next = cnt_reg;
      ST_INIT:
        if (user_init_clock_sel_i)
        begin
          cnt_next = (uclk_rise && uclk_en) ? cnt_reg + `PCL_CNT_ONE : cnt_reg;
          if (cnt_reg >= `PCL_USR_INIT_CYC)
            state_next = ST_USER;
        end
        else if (cnt_reg >= INIT_CYC[`PCL_CNT_W-1:0])
          state_next = ST_USER;
      ST_USER:
        cnt_next = `PCL_CNT_ZERO;
      default:
        state_next = ST_POR;
    endcase
    // request low aborts everything once power-on delay is over
    if (req_low && state_reg != ST_POR && state_reg != ST_RST)
    begin
      state_next = ST_RST;
      cnt_next   = `PCL_CNT_ZERO;
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg        <= ST_POR;
      cnt_reg          <= `PCL_CNT_ZERO;
      bytes_reg        <= `PCL_CNT_ZERO;
      edges_reg        <= 2'h0;
      stat_drv_reg     <= 1'b1;
      done_reg         <= 1'b0;
      init_done_o      <= 1'b0;
      user_mode_o      <= 1'b0;
      data_pins_user_o <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      stat_drv_reg <= (state_next == ST_POR) || (state_next == ST_RST);
      user_mode_o  <= (state_next == ST_USER);
      init_done_o  <= (state_next == ST_USER);
      data_pins_user_o <= (state_next == ST_USER) && data_pins_user_en_i;
      if (state_next == ST_POR || state_next == ST_RST || state_next == ST_WAIT)
      begin
        done_reg  <= 1'b0;
        bytes_reg <= `PCL_CNT_ZERO;
        edges_reg <= 2'h0;
      end
      else
      begin
        if (take)
        begin
          bytes_reg <= bytes_reg + `PCL_CNT_ONE;
          if (bytes_reg + `PCL_CNT_ONE >= BYTE_COUNT[`PCL_CNT_W-1:0])
            done_reg <= 1'b1;
        end
        if (done_reg && parallel_load_clock_fall && edges_reg != `PCL_DONE_EDGES)
          edges_reg <= edges_reg + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // user clock enable delay after done
  // ------------------------------------------------------------
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i || state_reg != ST_INIT)
      cu_cnt_reg <= `PCL_CNT_ZERO;
    else if (!uclk_en)
      cu_cnt_reg <= cu_cnt_reg + `PCL_CNT_ONE;
  end

  // ------------------------------------------------------------
  // pins: open drain, enable low while driving low
  // ------------------------------------------------------------
  assign load_status_n_o      = 1'b0;
  assign load_status_n_oe_n_o = ~stat_drv_reg;
  assign load_done_o          = 1'b0;
  assign load_done_oe_n_o     = done_reg;
  assign load_stall_o         = (state_reg == ST_LOAD) && !buf_ready;

  // ------------------------------------------------------------
  // byte buffer
  // ------------------------------------------------------------
  pcl_byte_buffer u_buf
  (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (take),
    .in_data_i   (data_s2_reg),
    .in_ready_o  (buf_ready),
    .out_valid_o (byte_valid_o),
    .out_data_o  (byte_data_o),
    .out_ready_i (byte_ready_i)
  );

endmodule
`default_nettype wire

//--- pkg/pcl_defs.vh
// constants for the parallel configuration load sequencer
`ifndef PCL_DEFS_VH
`define PCL_DEFS_VH

// clock rate in MHz (100 MHz system clock)
`define PCL_CLK_MHZ        100
// config-request low to done/status low, ns (longest)
`define PCL_T_REQ2LOW_NS   500
`define PCL_REQ2LOW_CYC    ((`PCL_T_REQ2LOW_NS * `PCL_CLK_MHZ) / 1000)
// status low pulse, us (least and longest)
`define PCL_T_STAT_MIN_US  45
`define PCL_T_STAT_MAX_US  230
`define PCL_STAT_MIN_CYC   (`PCL_T_STAT_MIN_US * `PCL_CLK_MHZ)
`define PCL_STAT_MAX_CYC   (`PCL_T_STAT_MAX_US * `PCL_CLK_MHZ)
// done high to user mode with internal oscillator, us (longest)
`define PCL_T_CD2UM_US     650
`define PCL_CD2UM_CYC      (`PCL_T_CD2UM_US * `PCL_CLK_MHZ)
// user-clock cycles needed for initialization
`define PCL_USR_INIT_CYC   17'h00C78
// system cycles from init start until the user clock is counted
`define PCL_CD2CU_CYC      17'h00040
// falling edges of load clock after done before init starts
`define PCL_DONE_EDGES     2'h2
// counter width
`define PCL_CNT_W          17
`define PCL_CNT_ZERO       17'h00000
`define PCL_CNT_ONE        17'h00001
// byte width
`define PCL_DATA_W         8
`define PCL_BYTE_ZERO      8'h00

`endif

//--- verilog/pcl_byte_buffer.v
// two-entry byte buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "pcl_defs.vh"

module pcl_byte_buffer
(
  // clock and reset
  input  wire                     sys_clk_i,
  input  wire                     sys_rst_i,
  // filling side
  input  wire                     in_valid_i,
  input  wire [`PCL_DATA_W-1:0]   in_data_i,
  output wire                     in_ready_o,
  // draining side
  output wire                     out_valid_o,
  output wire [`PCL_DATA_W-1:0]   out_data_o,
  input  wire                     out_ready_i
);

  reg [`PCL_DATA_W-1:0] mem_reg [0:1];
  reg                   wr_ptr_reg;
  reg                   rd_ptr_reg;
  reg [1:0]             count_reg;
  wire                  push;
  wire                  pop;

  assign in_ready_o  = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop)
        count_reg <= count_reg + 2'h1;
      else if (pop && !push)
        count_reg <= count_reg - 2'h1;
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data_i;
  end

endmodule
`default_nettype wire

//--- testbench/pcl_seq_props.sv
// assertions on the load sequencer ports
`timescale 1ns/1ps
`default_nettype none
module pcl_seq_props #(parameter int STAT_CYC = 20)
(
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       config_request_n_i,
  input wire logic       load_status_n_oe_n_o,
  input wire logic       load_done_oe_n_o,
  input wire logic       data_pins_user_en_i,
  input wire logic       data_pins_user_o,
  input wire logic       byte_valid_o,
  input wire logic [7:0] byte_data_o,
  input wire logic       byte_ready_i,
  input wire logic       init_done_o,
  input wire logic       user_mode_o,
  input wire logic       load_stall_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // length of the current status low pulse
  logic [16:0] low_cnt_reg;
  always_ff @(posedge sys_clk_i)
    low_cnt_reg <= (sys_rst_i || load_status_n_oe_n_o) ? 17'h00000 : low_cnt_reg + 17'h00001;
  AST_REQ_STATUS: assert property (user_mode_o && $fell(config_request_n_i) |-> ##[1:50] !load_status_n_oe_n_o)
    else $error("status not pulled low after request");
  AST_REQ_DONE: assert property (user_mode_o && $fell(config_request_n_i) |-> ##[1:50] !load_done_oe_n_o)
    else $error("done not pulled low after request");
  AST_USER_LINES: assert property (user_mode_o && $past(user_mode_o) |-> load_status_n_oe_n_o && load_done_oe_n_o)
    else $error("line pulled low in user mode");
  AST_POR_STATUS: assert property ($fell(sys_rst_i) |-> (!load_status_n_oe_n_o) [*8])
    else $error("status released early after reset");
  AST_RESET_DONE: assert property ($fell(sys_rst_i) |-> !load_done_oe_n_o && !user_mode_o && !init_done_o)
    else $error("done or user mode high after reset");
  AST_STAT_MIN: assert property ($rose(load_status_n_oe_n_o) |-> low_cnt_reg >= STAT_CYC - 1)
    else $error("status low pulse too short");
  AST_STALL_FULL: assert property (load_stall_o |-> byte_valid_o)
    else $error("stall without a held byte");
  AST_VALID_HOLD: assert property (byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_data_o))
    else $error("byte dropped while stalled");
  AST_PINS_USER: assert property (user_mode_o && $past(user_mode_o) |-> data_pins_user_o == data_pins_user_en_i)
    else $error("data pin option not applied");
  cover property ($rose(user_mode_o));
  cover property (load_stall_o);
  cover property ($rose(load_done_oe_n_o));
endmodule
bind pcl_load_sequencer pcl_seq_props #(.STAT_CYC(STAT_CYC)) i_props (.sys_clk_i, .sys_rst_i, .config_request_n_i,
  .load_status_n_oe_n_o, .load_done_oe_n_o, .data_pins_user_en_i, .data_pins_user_o, .byte_valid_o, .byte_data_o,
  .byte_ready_i, .init_done_o, .user_mode_o, .load_stall_o);
`default_nettype wire

//--- testbench/pcl_host_model.sv
// host that requests loading and clocks bytes in
`timescale 1ns/1ps
`default_nettype none
module pcl_host_model
(
  input  wire logic       status_n_i,
  output logic            req_n_o,
  output logic            lclk_o,
  output logic [7:0]      data_o
);
  // clock rests low between frames
  initial {req_n_o, lclk_o, data_o} = {1'b1, 1'b0, 8'h00};
  task automatic reconfig();
    req_n_o = 1'b0;
    #600 req_n_o = 1'b1;
    #230000 wait (status_n_i);
    #2000;
  endtask
  // one byte per 125 ns clock, scrambled once the clock falls
  task automatic send(input logic [7:0] b);
    data_o = b;
    #60 lclk_o = 1'b1;
    #62 lclk_o = 1'b0;
    data_o = ~b;
    #3;
  endtask
endmodule
`default_nettype wire

//--- testbench/test_parallel_config_load_sequencer.sv
// self-checking bench for the load sequencer
`timescale 1ns/1ps
`default_nettype none
module test_parallel_config_load_sequencer;
  localparam int S = 20;
  localparam int N = 4;
  logic sys_clk_i = 0, sys_rst_i = 1, byte_ready_i = 0, stall = 0;
  logic user_init_clock_i = 0, user_init_clock_sel_i = 0, data_pins_user_en_i = 1;
  wire  config_request_n_i, parallel_load_clock_i, load_status_n_o, load_status_n_oe_n_o, load_done_o;
  wire  load_done_oe_n_o, data_pins_user_o, byte_valid_o, init_done_o, user_mode_o, load_stall_o;
  wire  [7:0] load_data_i, byte_data_o;
  // pull-ups on the open-drain lines
  wire  load_status_n_i = load_status_n_oe_n_o ? 1'b1 : load_status_n_o;
  wire  load_done_i = load_done_oe_n_o ? 1'b1 : load_done_o;
  int   error_cnt = 0, cmp_count = 0, seed = 32'h3a7b;
  logic [7:0] exp_q[$], got_q[$];
  pcl_load_sequencer #(.STAT_CYC(S), .INIT_CYC(S), .POR_CYC(S), .BYTE_COUNT(N)) i_dut (.sys_clk_i, .sys_rst_i,
    .config_request_n_i, .load_status_n_i, .load_status_n_o, .load_status_n_oe_n_o, .load_done_i, .load_done_o,
    .load_done_oe_n_o, .parallel_load_clock_i, .load_data_i, .user_init_clock_i, .user_init_clock_sel_i,
    .data_pins_user_en_i, .data_pins_user_o, .byte_valid_o, .byte_data_o, .byte_ready_i, .init_done_o,
    .user_mode_o, .load_stall_o);
  pcl_host_model i_host (.status_n_i(load_status_n_i), .req_n_o(config_request_n_i),
    .lclk_o(parallel_load_clock_i), .data_o(load_data_i));
  always #5 sys_clk_i = ~sys_clk_i;
  always #20 user_init_clock_i = ~user_init_clock_i;
  always @(posedge sys_clk_i) #1 byte_ready_i = !stall && ($random(seed) % 4 != 0);
  always @(posedge sys_clk_i) if (byte_valid_o && byte_ready_i && !sys_rst_i) got_q.push_back(byte_data_o);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("mismatch %0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic round(input logic st, input logic en, input logic sel);
    int k;
    logic [7:0] b;
    fork
      i_host.reconfig();
      begin
        repeat (50) @(posedge sys_clk_i);
        #1 chk(load_status_n_i, 0);
        chk(load_done_i, 0);
      end
    join
    @(posedge sys_clk_i);
    #1 stall = st;
    data_pins_user_en_i = en;
    user_init_clock_sel_i = sel;
    for (k = 0; k < N; k++)
    begin
      b = k == 0 ? 8'h00 : k == N - 1 ? 8'hFF : 8'($random(seed));
      exp_q.push_back(b);
      i_host.send(b);
      if (k == 1 && st)
      begin
        repeat (5) @(posedge sys_clk_i);
        #1 chk(load_stall_o, 1);
        stall = 0;
      end
    end
    repeat (10) @(posedge sys_clk_i);
    #1 chk(load_done_i, 1);
    if (load_done_i !== 1'b1) i_host.reconfig();
    i_host.send(8'h5A);
    i_host.send(8'hA5);
    for (k = 0; k < 20000 && user_mode_o !== 1'b1; k++) @(posedge sys_clk_i);
    #1 chk(user_mode_o, 1);
    chk(init_done_o, 1);
    chk(load_status_n_i, 1);
    chk(load_done_i, 1);
    chk(data_pins_user_o, data_pins_user_en_i);
    chk(8'(got_q.size()), 8'(N));
    foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
    exp_q.delete();
    got_q.delete();
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    #1 sys_rst_i = 0;
    repeat (2) @(posedge sys_clk_i);
    #1 chk(load_status_n_i, 0);
    chk(load_done_i, 0);
    round(0, 1, 0);
    round(1, 0, 1);
    report_and_stop();
  end
  initial
  begin
    #1000000 error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
